// File: dv/fdm_fan_model.sv
// Fan model: spins while its drive duty is above zero
`timescale 1ns/100ps
module fdm_fan_model (
    input  logic [7:0] duty,
    output logic       spinning
);
    assign spinning = |duty;
endmodule

// File: dv/fdm_monitor.sv
// Port checker for the fan drive source mux
`timescale 1ns/100ps
module fdm_monitor (
    input logic       clk,
    input logic       rstn,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic [7:0] reg_rdata,
    input logic [7:0] fan_drive_1_duty,
    input logic [7:0] fan_drive_2_duty,
    input logic [7:0] fan_drive_3_duty,
    input logic [2:0] fan_drive_enabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    off_one_zero_a: assert property (!fan_drive_enabled[0] ##1
        !fan_drive_enabled[0] |-> fan_drive_1_duty == 8'h00) else $error("d1");
    off_three_zero_a: assert property (!fan_drive_enabled[2] ##1
        !fan_drive_enabled[2] |-> fan_drive_3_duty == 8'h00) else $error("d3");
    cfg_off_a: assert property (reg_wr && reg_addr == 8'h5c &&
        reg_wdata[7:5] == 3'h4 |=> !fan_drive_enabled[0]) else $error("en0");
    cfg_on_a: assert property (reg_wr && reg_addr == 8'h5d &&
        reg_wdata[7:5] != 3'h4 |=> fan_drive_enabled[1]) else $error("en1");
    full_two_a: assert property (reg_wr && reg_addr == 8'h5d &&
        reg_wdata[7:5] == 3'h3 |-> ##2 fan_drive_2_duty == 8'hff)
        else $error("full");
    duty_read_a: assert property (reg_rd && reg_addr == 8'h30 |=>
        reg_rdata == $past(fan_drive_1_duty)) else $error("rd30");
    unmapped_read_a: assert property (reg_rd && reg_addr == 8'h40
        |=> reg_rdata == 8'h00) else $error("rd40");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("hold");
endmodule
bind fdm_top fdm_monitor u_fdm_monitor (.clk, .rstn, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rdata, .fan_drive_1_duty, .fan_drive_2_duty,
    .fan_drive_3_duty, .fan_drive_enabled);

// File: dv/tb_fdm_top.sv
// Self-checking bench for the fan drive source mux
`timescale 1ns/100ps
module tb_fdm_top;
    logic        clk = 1'b0, rstn, reg_wr, reg_rd, duty_update, overtemp_signal;
    logic        spin;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, d1, d2, d3, r1, lo, r2;
    logic [2:0]  to_full, en;
    logic [23:0] dmax;
    int          err_count, checked;
    logic [2:0]  sel [5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
    logic [7:0]  expd [5] = '{8'ha0, 8'h60, 8'h70, 8'h70, 8'ha0};
    fdm_top u_fdm_top (.clk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata, .chan_duty_remote1(r1), .chan_duty_local(lo),
        .chan_duty_remote2(r2), .duty_update, .overtemp_signal,
        .overtemp_to_full(to_full), .duty_max(dmax), .fan_drive_1_duty(d1),
        .fan_drive_2_duty(d2), .fan_drive_3_duty(d3), .fan_drive_enabled(en));
    fdm_fan_model u_fdm_fan_model (.duty(d1), .spinning(spin));
    initial forever #5 clk = ~clk;
    task automatic stop_test();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        stop_test();
    end
    task automatic chk(string n, logic [7:0] e, logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic acc(logic w, logic [7:0] a, logic [7:0] d, string n);
        @(negedge clk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
        @(negedge clk);
        {reg_wr, reg_rd} = 2'b00;
        if (!w) chk(n, d, reg_rdata);
    endtask
    initial begin
        {rstn, reg_wr, reg_rd, overtemp_signal, to_full} = '0;
        {reg_addr, reg_wdata, r1, lo, r2, dmax} = {16'h0, 24'ha06070, 24'hc0};
        duty_update = 1'b1;
        repeat (16) @(negedge clk);
        chk("reset duty", 8'hff, d1);
        rstn = 1'b1;
        acc(0, 8'h5c, 8'h82, "cfg1");
        acc(0, 8'h30, 8'h00, "duty1");
        acc(0, 8'h40, 8'h00, "unmapped");
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            acc(1, 8'h5c, {sel[i], 5'h02}, "");
            @(negedge clk);
            chk("auto", expd[i], d1);
            acc(0, 8'h30, expd[i], "auto read");
        end
        acc(1, 8'h5e, 8'h02, "");
        duty_update = 1'b0;
        r1 = 8'h33;
        repeat (2) @(negedge clk);
        chk("no update", 8'h00, d3);
        duty_update = 1'b1;
        repeat (2) @(negedge clk);
        chk("shared", 8'h33, d3);
        chk("fastest", 8'h70, d1);
        $display("test modes done");
        acc(1, 8'h5d, 8'h62, "");
        acc(1, 8'h30, 8'h11, "");
        chk("full", 8'hff, d2);
        acc(0, 8'h30, 8'h70, "refused");
        acc(1, 8'h5c, 8'h82, "");
        @(negedge clk);
        chk("off", 8'h00, d1);
        acc(1, 8'h5c, 8'he2, "");
        acc(1, 8'h30, 8'h80, "");
        acc(0, 8'h30, 8'h80, "manual");
        chk("spin", 8'h01, {7'h0, spin});
        overtemp_signal = 1'b1;
        repeat (4) @(negedge clk);
        chk("ot max", 8'hc0, d1);
        to_full = 3'h1;
        repeat (3) @(negedge clk);
        chk("ot full", 8'hff, d1);
        $display("test manual done");
        stop_test();
    end
endmodule

// File: hdl/fdm_output_sel.v
// One fan drive output: behaviour mux and present duty register
`timescale 1ns/100ps
`include "fdm_consts.vh"
module fdm_output_sel #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [2:0]   behaviour_select,
    input  wire [W-1:0] duty_remote1,
    input  wire [W-1:0] duty_local,
    input  wire [W-1:0] duty_remote2,
    input  wire         update,
    input  wire         host_wr,
    input  wire [W-1:0] host_data,
    input  wire         overtemp,
    input  wire         overtemp_to_full,
    input  wire [W-1:0] duty_max,
    output reg  [W-1:0] duty
);
    reg [W-1:0] fast_lr2;
    reg [W-1:0] fast_all;
    reg [W-1:0] next_duty;

    always @* begin
        fast_lr2 = (duty_local > duty_remote2) ? duty_local : duty_remote2; // RULE_16
        fast_all = (duty_remote1 > fast_lr2) ? duty_remote1 : fast_lr2; // RULE_16
        next_duty = duty;
        case (behaviour_select)
            `FDM_BHV_REMOTE1:  if (update) next_duty = duty_remote1; // RULE_02
            `FDM_BHV_LOCAL:    if (update) next_duty = duty_local; // RULE_03
            `FDM_BHV_REMOTE2:  if (update) next_duty = duty_remote2; // RULE_04
            `FDM_BHV_FAST_LR2: if (update) next_duty = fast_lr2; // RULE_05
            `FDM_BHV_FAST_ALL: if (update) next_duty = fast_all; // RULE_06
            `FDM_BHV_FULL:     next_duty = `FDM_DUTY_FULL; // RULE_07
            `FDM_BHV_OFF:      next_duty = `FDM_DUTY_ZERO; // RULE_08
            `FDM_BHV_MANUAL: begin
                if (host_wr)
                    next_duty = host_data; // RULE_09
                if (overtemp)
                    next_duty = overtemp_to_full ? `FDM_DUTY_FULL
                                                 : duty_max; // RULE_10
            end
            default:           next_duty = duty;
        endcase
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            duty <= `FDM_DUTY_RESET; // RULE_14
        else
            duty <= next_duty;
    end
endmodule

// File: hdl/fdm_top.v
// Fan drive source mux: three outputs with register port
// Behaviour
// RULE_01: each output has its own 3-bit behaviour select in config bits 7:5.
// RULE_02: select 000 drives the output from the remote 1 channel duty.
// RULE_03: select 001 drives the output from the local channel duty.
// RULE_04: select 010 drives the output from the remote 2 channel duty.
// RULE_05: select 101 uses the faster of local and remote 2 duties.
// RULE_06: select 110 uses the fastest of all three channel duties.
// RULE_07: select 011 runs the output at full duty.
// RULE_08: select 100 disables the output; this is the reset value.
// RULE_09: select 111 lets host writes to present duty drive the output.
// RULE_10: manual mode over-temperature forces maximum duty or 100 percent.
// RULE_11: automatic control follows temperatures continuously without the host; the code loads a new duty only while duty_update is high.
// RULE_12: each temperature channel computes its duty independently, shareable.
// RULE_13: host reads data then writes the wanted manual duty.
// RULE_14: present duty registers are 8 bits and reset to full duty.
// RULE_15: present duty reads return the applied duty in every mode.
// RULE_16: fastest modes take the maximum of the selected channel duties.
`timescale 1ns/100ps
`include "fdm_consts.vh"
module fdm_top #(
    parameter W = 8
) (
    input  wire           clk,
    input  wire           rstn,
    input  wire           reg_wr,
    input  wire           reg_rd,
    input  wire [7:0]     reg_addr,
    input  wire [7:0]     reg_wdata,
    output reg  [7:0]     reg_rdata,
    input  wire [W-1:0]   chan_duty_remote1,
    input  wire [W-1:0]   chan_duty_local,
    input  wire [W-1:0]   chan_duty_remote2,
    input  wire           duty_update,
    input  wire           overtemp_signal,
    input  wire [2:0]     overtemp_to_full,
    input  wire [3*W-1:0] duty_max,
    output wire [W-1:0]   fan_drive_1_duty,
    output wire [W-1:0]   fan_drive_2_duty,
    output wire [W-1:0]   fan_drive_3_duty,
    output wire [2:0]     fan_drive_enabled
);
    reg  [7:0]     cfg [0:2];
    wire [3*W-1:0] duty_all;
    reg            ot_meta;
    reg            ot_sync;
    integer        i;

    // Over-temperature pin synchroniser
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ot_meta <= 1'b0;
            ot_sync <= 1'b0;
        end else begin
            ot_meta <= overtemp_signal;
            ot_sync <= ot_meta;
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (i = 0; i < 3; i = i + 1)
                cfg[i] <= `FDM_CFG_RESET; // RULE_08
        end else if (reg_wr) begin
            if (reg_addr == `FDM_ADDR_CFG1)
                cfg[0] <= reg_wdata; // RULE_01
            if (reg_addr == `FDM_ADDR_CFG2)
                cfg[1] <= reg_wdata; // RULE_01
            if (reg_addr == `FDM_ADDR_CFG3)
                cfg[2] <= reg_wdata; // RULE_01
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1) begin : gen_out
            // Present duty address of this output, kept 8 bits wide
            wire [7:0] duty_addr = (g == 0) ? `FDM_ADDR_DUTY1 :
                                   (g == 1) ? `FDM_ADDR_DUTY2 :
                                              `FDM_ADDR_DUTY3;
            wire wr_duty = reg_wr && (reg_addr == duty_addr);
            wire manual = (cfg[g][`FDM_BHV_HI:`FDM_BHV_LO]
                           == `FDM_BHV_MANUAL);
            // Channel duties shared by all outputs
            fdm_output_sel #(.W(W)) u_sel ( // RULE_12
                .clk              (clk),
                .rstn             (rstn),
                .behaviour_select (cfg[g][`FDM_BHV_HI:`FDM_BHV_LO]),
                .duty_remote1     (chan_duty_remote1),
                .duty_local       (chan_duty_local),
                .duty_remote2     (chan_duty_remote2),
                .update           (duty_update), // RULE_11
                .host_wr          (wr_duty && manual), // RULE_09
                .host_data        (reg_wdata[W-1:0]),
                .overtemp         (ot_sync),
                .overtemp_to_full (overtemp_to_full[g]),
                .duty_max         (duty_max[g*W +: W]),
                .duty             (duty_all[g*W +: W])
            );
            assign fan_drive_enabled[g] =
                (cfg[g][`FDM_BHV_HI:`FDM_BHV_LO] != `FDM_BHV_OFF);
        end
    endgenerate

    assign fan_drive_1_duty = duty_all[0 +: W];
    assign fan_drive_2_duty = duty_all[W +: W];
    assign fan_drive_3_duty = duty_all[2*W +: W];

    always @(posedge clk or negedge rstn) begin
        if (!rstn)
            reg_rdata <= 8'h00;
        else if (reg_rd) begin
            case (reg_addr)
                `FDM_ADDR_DUTY1: reg_rdata <= duty_all[0 +: W]; // RULE_15
                `FDM_ADDR_DUTY2: reg_rdata <= duty_all[W +: W]; // RULE_15
                `FDM_ADDR_DUTY3: reg_rdata <= duty_all[2*W +: W]; // RULE_15
                `FDM_ADDR_CFG1:  reg_rdata <= cfg[0];
                `FDM_ADDR_CFG2:  reg_rdata <= cfg[1];
                `FDM_ADDR_CFG3:  reg_rdata <= cfg[2];
                default:         reg_rdata <= 8'h00;
            endcase
        end
    end
endmodule

// File: inc/fdm_consts.vh
// Constants for the fan drive source mux
`ifndef FDM_CONSTS_VH
`define FDM_CONSTS_VH

`define FDM_ADDR_DUTY1     8'h30
`define FDM_ADDR_DUTY2     8'h31
`define FDM_ADDR_DUTY3     8'h32
`define FDM_ADDR_CFG1      8'h5c
`define FDM_ADDR_CFG2      8'h5d
`define FDM_ADDR_CFG3      8'h5e

`define FDM_BHV_HI         7
`define FDM_BHV_LO         5

`define FDM_BHV_REMOTE1    3'h0
`define FDM_BHV_LOCAL      3'h1
`define FDM_BHV_REMOTE2    3'h2
`define FDM_BHV_FULL       3'h3
`define FDM_BHV_OFF        3'h4
`define FDM_BHV_FAST_LR2   3'h5
`define FDM_BHV_FAST_ALL   3'h6
`define FDM_BHV_MANUAL     3'h7

`define FDM_CFG_RESET      8'h82
`define FDM_DUTY_RESET     8'hff
`define FDM_DUTY_FULL      8'hff
`define FDM_DUTY_ZERO      8'h00

`endif
